// >>> core/sbc_defines.svh
// Constants of the strap boot configuration block: strap codes, field
// positions and widths of the general control word.
// Assumes inclusion by bare name from the package and both ends.
`ifndef SBC_DEFINES_SVH
`define SBC_DEFINES_SVH

`define SBC_REFCLK_W        3
`define SBC_STARTUP_W       4
`define SBC_CTRL_W          6
// Reference clock strap codes
`define SBC_REF_125         3'h0
`define SBC_REF_156         3'h1
`define SBC_REF_250         3'h2
`define SBC_REF_25          3'h4
// Startup strap codes
`define SBC_SU_CPU_LE       4'h0
`define SBC_SU_PCIE         4'h9
`define SBC_SU_MGMT_0       4'hA
`define SBC_SU_MGMT_31      4'hB
`define SBC_SU_CPU_BE       4'hC
`define SBC_SU_HOLD         4'hF
// Management slave addresses
`define SBC_MGMT_ADDR_LO    5'h00
`define SBC_MGMT_ADDR_HI    5'h1F
// General control field positions
`define SBC_F_SI_OWNER      0
`define SBC_F_BOOT_MAP      1
`define SBC_F_CPU_HOLD      2
`define SBC_F_BIG_ENDIAN    3
`define SBC_F_MGMT_EN       4
`define SBC_F_PCIE_EN       5
// Reset value before any strap is caught: processor held, boot map on
`define SBC_CTRL_RST        6'h06
// Control reset values chosen by the caught startup strap
`define SBC_CTRL_LE         6'h03
`define SBC_CTRL_BE         6'h0B
`define SBC_CTRL_PCIE       6'h26
`define SBC_CTRL_MGMT       6'h16
// Host register offsets (byte addresses)
`define SBC_ADDR_CTRL       4'h0
`define SBC_ADDR_STATUS     4'h4
`define SBC_ADDR_STRAP      4'h8
`define SBC_ADDR_PORTSEL    4'hC

`endif

// >>> core/sbc_device.sv
// Device end: catches straps at reset release, derives the general
// control word, runs serial owner / boot map / debug port selection.
// Assumes straps are static around reset release and that the board
// never presents a reserved strap code.
//
// Behaviour
// RULE1 - Capture all straps at reset release
// RULE2 - Decode reference clock frequency select
// RULE3 - 0000: processor little endian, flash boot
// RULE4 - 1100: processor big endian, flash boot
// RULE5 - 1001: PCIe endpoint, hold, serial slave
// RULE6 - 1010/1011: management slave address 0/31
// RULE7 - 1111: hold processor, serial slave on
// RULE8 - Board never straps reserved codes
// RULE9 - Drive upper startup pins when ready (code drives them only for straps 1001/1010/1011)
// RULE10 - Startup strap sets control reset value
// RULE11 - Host flash boot: owner, map, release
// RULE12 - Serial owner disables serial slave
// RULE13 - Host memory boot: clear map, hold
// RULE14 - Boot byte order follows endian field
// RULE15 - Clearing owner frees serial slave
// RULE16 - Management enable claims overlaid pins
// RULE17 - Debug select low: processor debug
// RULE18 - Flash boot reserves serial interface
// RULE19 - Boot mapping after reset
// RULE20 - Map change takes effect on read
// RULE21 - Captured straps stable until reset
`timescale 1ns/1ps
`include "sbc_defines.svh"

module sbc_device (
  input  wire logic              clk_in,
  input  wire logic              rst_b_in,
  sbc_if.device                  link,
  input  wire logic              port_ready_in,
  input  wire logic              debug_port_select_n_in,
  output sbc_pkg::sbc_freq_t     ref_freq_out,
  output logic                   cpu_run_out,
  output logic                   cpu_big_endian_out,
  output sbc_pkg::sbc_map_t      bus_map_out,
  output logic                   serial_slave_en_out,
  output logic                   serial_boot_out,
  output logic                   mgmt_slave_en_out,
  output logic [4:0]             mgmt_addr_out,
  output logic                   pcie_en_out,
  output logic                   debug_to_cpu_out
);
  import sbc_pkg::*;

  logic [3:0] su_meta;
  logic [3:0] su_sync;
  logic [2:0] rc_meta;
  logic [2:0] rc_sync;
  logic       dbg_meta;
  logic       dbg_sync;
  logic       rst_seen;     // Low during reset, first cycle after marks release
  logic       captured;
  logic [3:0] startup_strap;
  logic [2:0] refclk_freq_strap;
  logic [5:0] ctrl;
  logic [5:0] next_ctrl;
  logic       map_boot;
  logic       pend_map;
  logic       drive_up;

  // Pins come from the board: two flops before any use
  always_ff @(posedge clk_in) begin
    su_meta  <= link.startup_pin_in;
    su_sync  <= su_meta;
    rc_meta  <= link.refclk_pin;
    rc_sync  <= rc_meta;
    dbg_meta <= debug_port_select_n_in;
    dbg_sync <= dbg_meta;
  end

  // Release marker, captured flag
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      rst_seen <= 1'b0;
      captured <= 1'b0;
    end else begin
      rst_seen <= 1'b1;
      captured <= rst_seen;
    end
  end

  // RULE1 strap capture once
  // Sampled on the second cycle after release so synchronised values
  // reflect the pins as held through reset
  // RULE21 hold until reset
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      startup_strap     <= 4'h0;
      refclk_freq_strap <= 3'h0;
    end else if (rst_seen && !captured) begin
      startup_strap     <= su_sync;
      refclk_freq_strap <= rc_sync;
    end
  end

  // RULE2 frequency decode
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      ref_freq_out <= SBC_FREQ_125;
    end else begin
      unique case (refclk_freq_strap)
        `SBC_REF_125: ref_freq_out <= SBC_FREQ_125;
        `SBC_REF_156: ref_freq_out <= SBC_FREQ_156_25;
        `SBC_REF_250: ref_freq_out <= SBC_FREQ_250;
        `SBC_REF_25:  ref_freq_out <= SBC_FREQ_25;
        default:      ref_freq_out <= SBC_FREQ_BAD;
      endcase
    end
  end

  // RULE10 control reset value from strap, host writes after
  always_comb begin
    next_ctrl = ctrl;
    if (rst_seen && !captured) begin
      next_ctrl = `SBC_CTRL_RST;
      unique case (su_sync)
        // RULE3 little endian flash boot
        `SBC_SU_CPU_LE: next_ctrl = `SBC_CTRL_LE;
        // RULE4 big endian flash boot
        `SBC_SU_CPU_BE: next_ctrl = `SBC_CTRL_BE;
        // RULE5 endpoint, processor held
        `SBC_SU_PCIE:   next_ctrl = `SBC_CTRL_PCIE;
        // RULE6 management slave on
        `SBC_SU_MGMT_0,
        `SBC_SU_MGMT_31: next_ctrl = `SBC_CTRL_MGMT;
        // RULE7 hold only
        `SBC_SU_HOLD:   next_ctrl = `SBC_CTRL_RST;
        default:        next_ctrl = `SBC_CTRL_RST;
      endcase
    end else if (link.ctrl_we && captured) begin
      // RULE11 host sets owner, map, release
      // RULE13 host clears map and hold
      // RULE16 management enable write
      next_ctrl = link.ctrl_wdata;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      ctrl <= `SBC_CTRL_RST;
    end else begin
      ctrl <= next_ctrl;
    end
  end

  // RULE19 boot mapping after reset
  // RULE20 written map applies at next read
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      map_boot <= 1'b1;
      pend_map <= 1'b0;
    end else begin
      if (link.ctrl_we) begin
        pend_map <= 1'b1;
      end else if (link.ctrl_re && pend_map) begin
        pend_map <= 1'b0;
        map_boot <= ctrl[`SBC_F_BOOT_MAP];
      end
    end
  end

  // Host read port answers one cycle after the strobe
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      link.ctrl_rdata  <= 6'h00;
      link.ctrl_rvalid <= 1'b0;
      link.strap_cap   <= 4'h0;
    end else begin
      link.ctrl_rdata  <= ctrl;
      link.ctrl_rvalid <= link.ctrl_re;
      link.strap_cap   <= startup_strap;
    end
  end

  // RULE9 drive upper startup pins when port ready and the caught strap is 1001, 1010 or 1011
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      drive_up <= 1'b0;
    end else begin
      drive_up <= captured && port_ready_in &&
                  (startup_strap == `SBC_SU_PCIE ||
                   startup_strap == `SBC_SU_MGMT_0 ||
                   startup_strap == `SBC_SU_MGMT_31);
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      link.startup_pin_out <= 4'h0;
      link.startup_pin_oe  <= 4'h0;
    end else begin
      link.startup_pin_out <= {drive_up, drive_up, 2'b00};
      link.startup_pin_oe  <= {drive_up, drive_up, 2'b00};
    end
  end

  // Control word outputs, all registered
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      cpu_run_out         <= 1'b0;
      cpu_big_endian_out  <= 1'b0;
      bus_map_out         <= SBC_MAP_BOOT;
      serial_slave_en_out <= 1'b0;
      serial_boot_out     <= 1'b0;
      mgmt_slave_en_out   <= 1'b0;
      mgmt_addr_out       <= `SBC_MGMT_ADDR_LO;
      pcie_en_out         <= 1'b0;
      debug_to_cpu_out    <= 1'b0;
    end else begin
      cpu_run_out        <= captured && !ctrl[`SBC_F_CPU_HOLD];
      // RULE14 byte order from control
      cpu_big_endian_out <= ctrl[`SBC_F_BIG_ENDIAN];
      bus_map_out        <= map_boot ? SBC_MAP_BOOT : SBC_MAP_NORMAL;
      // RULE12 owner blocks serial slave
      // RULE15 clearing owner frees slave
      serial_slave_en_out <= captured && !ctrl[`SBC_F_SI_OWNER];
      // RULE18 serial reserved for boot
      serial_boot_out    <= captured && ctrl[`SBC_F_SI_OWNER];
      // RULE16 management slave takes pins
      mgmt_slave_en_out  <= ctrl[`SBC_F_MGMT_EN];
      mgmt_addr_out      <= (startup_strap == `SBC_SU_MGMT_31) ?
                            `SBC_MGMT_ADDR_HI : `SBC_MGMT_ADDR_LO;
      pcie_en_out        <= ctrl[`SBC_F_PCIE_EN];
      // RULE17 low selects processor debug
      debug_to_cpu_out   <= !dbg_sync;
    end
  end
endmodule

// >>> core/sbc_host.sv
// Host end: Wishbone classic slave holding command registers, turned
// into control writes and reads on the link.
// Assumes a single-clock Wishbone master; acks one cycle after request.
`timescale 1ns/1ps
`include "sbc_defines.svh"

module sbc_host (
  input  wire logic        clk_in,
  input  wire logic        rst_b_in,
  sbc_if.host              link,
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [3:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic [31:0]      wb_dat_out,
  output logic             wb_ack_out
);
  import sbc_pkg::*;

  logic [5:0] shadow;   // Last control value read back
  logic       req;

  assign req = wb_cyc_in && wb_stb_in && !wb_ack_out;

  // Bus answer: one-cycle ack, unmapped reads zero
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0000_0000;
    end else begin
      wb_ack_out <= req;
      wb_dat_out <= 32'h0000_0000;
      if (req && !wb_we_in) begin
        unique case (wb_adr_in)
          `SBC_ADDR_CTRL:   wb_dat_out <= {26'h0, shadow};
          `SBC_ADDR_STRAP:  wb_dat_out <= {28'h0, link.strap_cap};
          default:          wb_dat_out <= 32'h0000_0000;
        endcase
      end
    end
  end

  // RULE11 RULE13 control writes; a read of control refreshes it and
  // applies a pending map change
  // RULE20 write then read
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      link.ctrl_we    <= 1'b0;
      link.ctrl_wdata <= `SBC_CTRL_RST;
      link.ctrl_re    <= 1'b0;
    end else begin
      link.ctrl_we <= req && wb_we_in && wb_sel_in[0] &&
                      wb_adr_in == `SBC_ADDR_CTRL;
      link.ctrl_re <= req && !wb_we_in && wb_adr_in == `SBC_ADDR_CTRL;
      if (req && wb_we_in && wb_adr_in == `SBC_ADDR_CTRL) begin
        link.ctrl_wdata <= wb_dat_in[5:0];
      end
    end
  end

  // Mirror of device control word
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      shadow <= `SBC_CTRL_RST;
    end else if (link.ctrl_rvalid) begin
      shadow <= link.ctrl_rdata;
    end
  end
endmodule

// >>> core/sbc_if.sv
// Link between the strap/config device end and the controlling host end.
// Assumes one clock shared by both ends; the bench resolves pin wires.
`timescale 1ns/1ps

interface sbc_if (
  input wire logic clk_in
);
  logic [3:0] startup_pin_in;     // Startup strap pin level seen by device
  logic [3:0] startup_pin_out;    // Device drive of startup pins
  logic [3:0] startup_pin_oe;     // High while device drives a pin
  logic [2:0] refclk_pin;         // Reference clock strap pin level
  logic       ctrl_we;            // Control write strobe from host
  logic [5:0] ctrl_wdata;         // Control write data
  logic       ctrl_re;            // Control read strobe from host
  logic [5:0] ctrl_rdata;         // Control read data
  logic       ctrl_rvalid;        // Read data valid pulse
  logic [3:0] strap_cap;          // Captured startup strap

  modport device (
    input  startup_pin_in, refclk_pin, ctrl_we, ctrl_wdata, ctrl_re,
    output startup_pin_out, startup_pin_oe, ctrl_rdata, ctrl_rvalid,
           strap_cap
  );
  modport host (
    output ctrl_we, ctrl_wdata, ctrl_re,
    input  ctrl_rdata, ctrl_rvalid, strap_cap
  );
endinterface

// >>> core/sbc_pkg.sv
// Types of the strap boot configuration block.
// Assumes sbc_defines.svh on the include path.
`include "sbc_defines.svh"

package sbc_pkg;
  typedef enum logic [2:0] {
    SBC_FREQ_125,
    SBC_FREQ_156_25,
    SBC_FREQ_250,
    SBC_FREQ_25,
    SBC_FREQ_BAD
  } sbc_freq_t;

  typedef enum logic [1:0] {
    SBC_MAP_BOOT,
    SBC_MAP_NORMAL
  } sbc_map_t;
endpackage

// >>> testbench/sbc_props.sv
// Checker on the link between the device and host ends.
// Assumes one clock and the bench's synchronous active-low reset.
`timescale 1ns/1ps

module sbc_props (
  input wire logic       clk_in,
  input wire logic       rst_b_in,
  input wire logic [3:0] startup_pin_in,
  input wire logic [3:0] startup_pin_out,
  input wire logic [3:0] startup_pin_oe,
  input wire logic       ctrl_we,
  input wire logic       ctrl_re,
  input wire logic       ctrl_rvalid,
  input wire logic [3:0] strap_cap
);
  logic [2:0] run_cnt;

  default clocking @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);

  // Cycles since reset release; saturates so late checks stay armed
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      run_cnt <= 3'h0;
    end else if (run_cnt != 3'h7) begin
      run_cnt <= run_cnt + 3'h1;
    end
  end

  a_capture_taken: assert property (
    run_cnt == 3'h5 && $stable(startup_pin_in) |-> strap_cap == startup_pin_in)
    else $error("strap not caught from pins");
  a_strap_held: assert property (
    run_cnt == 3'h7 |-> $stable(strap_cap))
    else $error("caught strap moved");
  a_drive_codes: assert property (
    |startup_pin_oe |-> strap_cap inside {4'h9, 4'hA, 4'hB})
    else $error("pins driven for wrong code");
  a_drive_upper: assert property (
    |startup_pin_oe |-> startup_pin_oe == 4'hC && startup_pin_out[3:2] == 2'h3)
    else $error("ready drive not upper pins high");
  a_read_answer: assert property (
    ctrl_re |=> ctrl_rvalid)
    else $error("read strobe not answered");
  a_answer_cause: assert property (
    ctrl_rvalid |-> $past(ctrl_re))
    else $error("read valid without strobe");
  a_write_pulse: assert property (
    ctrl_we |=> !ctrl_we)
    else $error("write strobe longer than one cycle");
  a_read_pulse: assert property (
    ctrl_re |=> !ctrl_re)
    else $error("read strobe longer than one cycle");
endmodule

// >>> testbench/strap_boot_configuration_bench.sv
// Bench joining device and host ends; drives straps and Wishbone.
// Assumes core files compiled first and a 40 MHz single clock.
`timescale 1ns/1ps

module strap_boot_configuration_bench;
  import sbc_pkg::*;
  logic        clk_in, rst_b_in, rdy, dbg_n, cyc, stb, we, ack;
  logic        run, be, sse, sboot, mge, pce, dbg;
  logic [3:0]  adr, straps, sel;
  logic [2:0]  refclk;
  logic [4:0]  mga;
  logic [31:0] dat_w, dat_r;
  logic [32:0] note;
  sbc_freq_t   freq;
  sbc_map_t    map, pmap;
  integer      seed = 79721;
  int          err_total = 0, checks_done = 0, cyc_cnt = 0;
  logic [32:0] notes[$];
  logic [3:0]  su_tab[6] = '{4'h0, 4'hC, 4'h9, 4'hA, 4'hB, 4'hF};
  logic [5:0]  cw_tab[6] = '{6'h03, 6'h0B, 6'h26, 6'h16, 6'h16, 6'h06};
  logic [2:0]  rc_tab[6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h0, 3'h1};
  logic [5:0]  hw_tab[4] = '{6'h03, 6'h02, 6'h00, 6'h18};
  sbc_freq_t   fq_tab[6] = '{SBC_FREQ_125, SBC_FREQ_156_25, SBC_FREQ_250,
                             SBC_FREQ_25, SBC_FREQ_125, SBC_FREQ_156_25};

  // Clock at 25 ns period
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end

  // Pin level: device drive wins, else the board's strap resistors
  sbc_if sbc_if_i (.clk_in(clk_in));
  assign sbc_if_i.startup_pin_in = (sbc_if_i.startup_pin_oe &
    sbc_if_i.startup_pin_out) | (~sbc_if_i.startup_pin_oe & straps);
  assign sbc_if_i.refclk_pin = refclk;

  sbc_device sbc_device_i (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .link(sbc_if_i), .port_ready_in(rdy), .debug_port_select_n_in(dbg_n),
    .ref_freq_out(freq), .cpu_run_out(run), .cpu_big_endian_out(be),
    .bus_map_out(map), .serial_slave_en_out(sse), .serial_boot_out(sboot),
    .mgmt_slave_en_out(mge), .mgmt_addr_out(mga), .pcie_en_out(pce),
    .debug_to_cpu_out(dbg));
  sbc_host sbc_host_i (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .link(sbc_if_i), .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we),
    .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(dat_w),
    .wb_dat_out(dat_r), .wb_ack_out(ack));
  sbc_props sbc_props_i (.clk_in(clk_in), .rst_b_in(rst_b_in),
    .startup_pin_in(sbc_if_i.startup_pin_in),
    .startup_pin_out(sbc_if_i.startup_pin_out),
    .startup_pin_oe(sbc_if_i.startup_pin_oe), .ctrl_we(sbc_if_i.ctrl_we),
    .ctrl_re(sbc_if_i.ctrl_re), .ctrl_rvalid(sbc_if_i.ctrl_rvalid),
    .strap_cap(sbc_if_i.strap_cap));

  task automatic check(input logic [31:0] seen, exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Classic cycle; a read leaves a note; care=0 for stale first reads
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [5:0] v, input logic care);
    logic [31:0] d;
    d = $random(seed);
    d[5:0] = v;
    if (!w) begin
      notes.push_back({care, 26'h0, v});
    end
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'hF;
    adr <= a;
    dat_w <= d;
    @(posedge clk_in);
    while (ack !== 1'b1) @(posedge clk_in);
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_in);
  endtask

  task automatic outs(input logic [5:0] cw);
    check(32'(run), 32'(!cw[2]), "cpu run");
    check(32'(sse), 32'(!cw[0]), "serial slave");
    check(32'(sboot), 32'(cw[0]), "serial boot");
    check(32'(be), 32'(cw[3]), "big endian");
    check(32'(mge), 32'(cw[4]), "mgmt slave");
    check(32'(pce), 32'(cw[5]), "pcie");
  endtask

  // Read answers are matched to the oldest note
  always @(posedge clk_in) begin
    if (ack === 1'b1 && we === 1'b0) begin
      note = notes.pop_front();
      if (note[32]) begin
        check(dat_r, note[31:0], "read data");
      end
    end
  end

  // Hang guard
  always @(posedge clk_in) begin
    cyc_cnt++;
    if (cyc_cnt == 5000) begin
      err_total++;
      tally_and_finish;
    end
  end

  initial begin
    {dbg_n, cyc, stb, we, adr, sel, dat_w} <= '0;
    for (int i = 0; i < 6; i++) begin
      rst_b_in <= 1'b0;
      rdy <= 1'b0;
      straps <= su_tab[i];
      refclk <= rc_tab[i];
      repeat (20) @(posedge clk_in);
      rst_b_in <= 1'b1;
      repeat (8) @(posedge clk_in);
      check(32'(sbc_if_i.strap_cap), 32'(su_tab[i]), "strap");
      check(32'(freq), 32'(fq_tab[i]), "ref freq");
      check(32'(map), 32'(SBC_MAP_BOOT), "map");
      outs(cw_tab[i]);
      if (cw_tab[i][4]) begin
        check(32'(mga), 32'({5{su_tab[i][0]}}), "mgmt addr");
      end
      bus(1'b0, 4'h0, 6'h00, 1'b0);
      bus(1'b0, 4'h0, cw_tab[i], 1'b1);
      straps <= 4'($random(seed));
      dbg_n <= 1'($random(seed));
      rdy <= 1'b1;
      repeat (6) @(posedge clk_in);
      check(32'(sbc_if_i.strap_cap), 32'(su_tab[i]), "strap held");
      check(32'(dbg), 32'(!dbg_n), "debug port");
      check(32'({sbc_if_i.startup_pin_oe[3:2], sbc_if_i.startup_pin_in[3:2]}),
        (i >= 2 && i <= 4) ? 32'hF : 32'({2'h0, straps[3:2]}), "drive");
      $display("strap test %0d done", i);
    end
    pmap = SBC_MAP_BOOT;
    for (int k = 0; k < 4; k++) begin
      bus(1'b1, 4'h0, hw_tab[k], 1'b0);
      repeat (3) @(posedge clk_in);
      check(32'(map), 32'(pmap), "map before read");
      bus(1'b0, 4'h0, 6'h00, 1'b0);
      bus(1'b0, 4'h0, hw_tab[k], 1'b1);
      repeat (3) @(posedge clk_in);
      pmap = hw_tab[k][1] ? SBC_MAP_BOOT : SBC_MAP_NORMAL;
      check(32'(map), 32'(pmap), "map after read");
      outs(hw_tab[k]);
    end
    // Reserved offsets read zero and ignore writes
    bus(1'b1, 4'h4, 6'h3F, 1'b0);
    bus(1'b0, 4'h4, 6'h00, 1'b1);
    bus(1'b0, 4'hC, 6'h00, 1'b1);
    repeat (2) @(posedge clk_in);
    $display("host test done");
    tally_and_finish;
  end
endmodule
